/* rtl/bnva_cell_array.sv */
`timescale 1ns/100ps
module bnva_cell_array
#(
  parameter int DEPTH = bnva_pkg::DEPTH,
  parameter int WRITE_CYC = bnva_pkg::NVM_WRITE_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  bnva_mem_if.mem mp
);
  import bnva_pkg::*;

  localparam logic [15:0] LAST_CNT = 16'(WRITE_CYC - 1);

  generate
    if (DEPTH != (1 << AW) || WRITE_CYC < 1 || WRITE_CYC > 65535)
    begin : g_bad
      $error("bnva_cell_array: unsupported DEPTH or WRITE_CYC");
    end
  endgenerate

  bnva_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] mem_d [DEPTH];
  logic mem_we;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    mem_we = 1'b0;
    unique case (state_q)
      BNVA_IDLE:
      begin
        addr_d = mp.addr;
        wdata_d = mp.wdata;
        cnt_d = 16'h0000;
        if (mp.req_wr)
          state_d = BNVA_WRITE;
        else if (mp.req_rd)
          state_d = BNVA_READ;
      end
      BNVA_READ:
      begin
        rdata_d = mem_q[addr_q];
        done_d = 1'b1;
        state_d = BNVA_IDLE;
      end
      BNVA_WRITE:
      begin
        if (cnt_q == LAST_CNT)
        begin
          mem_we = 1'b1;
          done_d = 1'b1;
          state_d = BNVA_IDLE;
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      default:
        state_d = BNVA_IDLE;
    endcase
  end

  // Thirty-two bytes, kept out of any address space
  always_comb
  begin
    mem_d = mem_q;
    if (mem_we)
      mem_d[addr_q] = wdata_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= BNVA_IDLE;
      cnt_q <= 16'h0000;
      addr_q <= ADDR_RST;
      wdata_q <= DATA_RST;
      rdata_q <= DATA_RST;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // Contents survive reset: the store is nonvolatile
  always_ff @(posedge clk)
  begin
    if (ce)
      mem_q <= mem_d;
  end

  assign mp.rdata = rdata_q;
  assign mp.done = done_q;
  assign mp.busy = (state_q != BNVA_IDLE);

  property p_write_lands;
    @(posedge clk) disable iff (!rstn)
    (ce && mem_we) |=> (mem_q[$past(addr_q)] == $past(wdata_q));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("stored byte lost");

  property p_write_len;
    @(posedge clk) disable iff (!rstn)
    (ce && mem_we) |-> (state_q == BNVA_WRITE && cnt_q == LAST_CNT);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write cycle length wrong");
endmodule

/* rtl/bnva_mem_if.sv */
`timescale 1ns/100ps
interface bnva_mem_if;
  logic req_rd;
  logic req_wr;
  logic [bnva_pkg::AW-1:0] addr;
  logic [bnva_pkg::DW-1:0] wdata;
  logic [bnva_pkg::DW-1:0] rdata;
  logic done;
  logic busy;
  modport ctrl (output req_rd, output req_wr, output addr, output wdata,
                input rdata, input done, input busy);
  modport mem (input req_rd, input req_wr, input addr, input wdata,
               output rdata, output done, output busy);
endinterface

/* rtl/bnva_pkg.sv */
package bnva_pkg;
  localparam int DW = 8;
  localparam int AW = 5;
  localparam int DEPTH = 32;

  // Bank 0 special function register offsets, and the bank 1 control register
  localparam logic [7:0] NVM_ADDR_OFS = 8'h3C;
  localparam logic [7:0] NVM_DATA_OFS = 8'h3D;
  localparam logic [7:0] BANK_SEL_OFS = 8'h3E;
  localparam logic [7:0] NVM_CTL_OFS = 8'h40;

  localparam int BANK_BIT = 0;
  localparam int CTL_RSV_BIT = 7;
  localparam int CTL_STORE_UNLOCK = 3;
  localparam int CTL_STORE_TRIG = 2;
  localparam int CTL_FETCH_UNLOCK = 1;
  localparam int CTL_FETCH_TRIG = 0;

  localparam logic BANK_RST = 1'b0;
  localparam logic [AW-1:0] ADDR_RST = 5'h00;
  localparam logic [DW-1:0] DATA_RST = 8'h00;
  localparam logic CTL_BIT_RST = 1'b0;

  localparam int CLK_PERIOD_NS = 100;
  localparam int NVM_WRITE_TIME_NS = 2000;
  localparam int NVM_WRITE_CYC = (NVM_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    BNVA_IDLE = 2'b00,
    BNVA_READ = 2'b01,
    BNVA_WRITE = 2'b11
  } bnva_state_t;
endpackage

/* rtl/bnva_top.sv */
`timescale 1ns/100ps
module bnva_top
#(
  parameter int WRITE_CYC = bnva_pkg::NVM_WRITE_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wdt_idle_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_ind,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [bnva_pkg::DW-1:0] sfr_wdata,
  output logic [bnva_pkg::DW-1:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic nvm_busy
);
  import bnva_pkg::*;

  logic bank_q, bank_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] data_q, data_d;
  logic rsv_q, rsv_d;
  logic st_unl_q, st_unl_d;
  logic st_trg_q, st_trg_d;
  logic fe_unl_q, fe_unl_d;
  logic fe_trg_q, fe_trg_d;
  logic fresh_q, fresh_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic rvalid_q;
  logic sel_b0, hit_bank, hit_addr, hit_data, hit_ctl;
  logic [DW-1:0] ctl_val, rd_val;
  logic start_rd, start_wr;

  bnva_mem_if mif ();

  bnva_cell_array #(
    .DEPTH(DEPTH),
    .WRITE_CYC(WRITE_CYC)
  ) u_array (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .mp(mif)
  );

  always_comb
  begin
    sel_b0 = !sfr_ind || !bank_q;
    hit_bank = sel_b0 && (sfr_addr == BANK_SEL_OFS);
    hit_addr = sel_b0 && (sfr_addr == NVM_ADDR_OFS);
    hit_data = sel_b0 && (sfr_addr == NVM_DATA_OFS);
    hit_ctl = sfr_ind && bank_q && (sfr_addr == NVM_CTL_OFS);
    ctl_val = {rsv_q, 3'b000, st_unl_q, st_trg_q, fe_unl_q, fe_trg_q};
    rd_val = '0;
    // bank bits 7 to 1 zero
    if (hit_bank)
      rd_val = {7'h00, bank_q};
    else if (hit_addr)
      rd_val = {3'h0, addr_q};
    else if (hit_data)
      rd_val = data_q;
    else if (hit_ctl)
      rd_val = ctl_val;
  end

  always_comb
  begin
    bank_d = bank_q;
    addr_d = addr_q;
    data_d = data_q;
    rsv_d = rsv_q;
    st_unl_d = st_unl_q;
    st_trg_d = st_trg_q;
    fe_unl_d = fe_unl_q;
    fe_trg_d = fe_trg_q;
    fresh_d = 1'b0;
    start_rd = 1'b0;
    start_wr = 1'b0;
    rdata_d = sfr_rd ? rd_val : rdata_q;
    if (sfr_wr)
    begin
      if (hit_bank)
        bank_d = sfr_wdata[BANK_BIT];
      if (hit_addr)
        addr_d = sfr_wdata[AW-1:0];
      if (hit_data)
        data_d = sfr_wdata;
      if (hit_ctl)
      begin
        rsv_d = sfr_wdata[CTL_RSV_BIT];
        st_unl_d = sfr_wdata[CTL_STORE_UNLOCK];
        fe_unl_d = sfr_wdata[CTL_FETCH_UNLOCK];
        fresh_d = sfr_wdata[CTL_STORE_UNLOCK];
        if (sfr_wdata[CTL_STORE_TRIG] && st_unl_q && fresh_q && !mif.busy && !st_trg_q)
        begin
          st_trg_d = 1'b1;
          start_wr = 1'b1;
        end
        else if (sfr_wdata[CTL_FETCH_TRIG] && fe_unl_q && !mif.busy && !fe_trg_q)
        begin
          fe_trg_d = 1'b1;
          start_rd = 1'b1;
        end
      end
    end
    // read byte lands in data
    // Clear only the finished trigger, so a start in the same cycle survives
    if (mif.done)
    begin
      if (fe_trg_q)
      begin
        data_d = mif.rdata;
        fe_trg_d = 1'b0;
      end
      if (st_trg_q)
        st_trg_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      if (!wdt_idle_rst)
        bank_q <= BANK_RST;
      addr_q <= ADDR_RST;
      data_q <= DATA_RST;
      rsv_q <= CTL_BIT_RST;
      st_unl_q <= CTL_BIT_RST;
      st_trg_q <= CTL_BIT_RST;
      fe_unl_q <= CTL_BIT_RST;
      fe_trg_q <= CTL_BIT_RST;
      fresh_q <= 1'b0;
      rdata_q <= DATA_RST;
      rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      bank_q <= bank_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rsv_q <= rsv_d;
      st_unl_q <= st_unl_d;
      st_trg_q <= st_trg_d;
      fe_unl_q <= fe_unl_d;
      fe_trg_q <= fe_trg_d;
      fresh_q <= fresh_d;
      rdata_q <= rdata_d;
      rvalid_q <= sfr_rd;
    end
  end

  assign mif.req_rd = ce && start_rd;
  assign mif.req_wr = ce && start_wr;
  assign mif.addr = addr_q;
  assign mif.wdata = data_q;

  assign sfr_rdata = rdata_q;
  assign sfr_rvalid = rvalid_q;
  assign nvm_busy = st_trg_q || fe_trg_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_ctl_wr(int b);
    ce && sfr_wr && sfr_ind && bank_q && sfr_addr == NVM_CTL_OFS && sfr_wdata[b];
  endsequence

  property p_bank_reset;
    $past(!rstn && !wdt_idle_rst) |-> !bank_q;
  endproperty
  a_bank_reset: assert property (p_bank_reset) else $error("bank not cleared");

  property p_bank_keep;
    $past(!rstn && wdt_idle_rst) |-> bank_q == $past(bank_q, 2);
  endproperty
  a_bank_keep: assert property (p_bank_keep) else $error("bank lost on wdt reset");

  property p_bank_write;
    (ce && sfr_wr && hit_bank) |=> bank_q == $past(sfr_wdata[0]);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank bit not stored");

  property p_direct_no_ctl;
    (ce && sfr_wr && !sfr_ind && st_trg_q == 1'b0 && fe_trg_q == 1'b0) |=> !nvm_busy;
  endproperty
  a_direct_no_ctl: assert property (p_direct_no_ctl) else $error("direct access hit ctl");

  property p_read_zero;
    (ce && sfr_rd && (hit_bank || hit_addr || hit_ctl))
      |=> sfr_rvalid
        && ((sfr_rdata & ($past(hit_bank) ? 8'hFE : ($past(hit_addr) ? 8'hE0 : 8'h70)))
          == 8'h00);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unused bits not zero");

  property p_fetch_gate;
    (s_ctl_wr(CTL_FETCH_TRIG) and (!fe_unl_q && !st_trg_q && !fe_trg_q)) |=> !fe_trg_q;
  endproperty
  a_fetch_gate: assert property (p_fetch_gate) else $error("read without unlock");

  property p_store_gate;
    (s_ctl_wr(CTL_STORE_TRIG) and (!fresh_q && !st_trg_q)) |=> !st_trg_q;
  endproperty
  a_store_gate: assert property (p_store_gate) else $error("write without unlock");

  property p_fetch_done;
    (ce && mif.done && fe_trg_q) |=> !fe_trg_q && data_q == $past(mif.rdata);
  endproperty
  a_fetch_done: assert property (p_fetch_done) else $error("read not completed");

  property p_fetch_time;
    (ce && start_rd) |=> fe_trg_q ##1 (!$past(ce) || mif.done);
  endproperty
  a_fetch_time: assert property (p_fetch_time) else $error("read took wrong time");

  property p_addr_width;
    (ce && sfr_rd && hit_addr) |=> sfr_rdata[7:5] == 3'b000;
  endproperty
  a_addr_width: assert property (p_addr_width) else $error("address upper bits set");
endmodule

/* sim/test_banked_nvm_register_access.sv */
`timescale 1ns/100ps
module test_banked_nvm_register_access;
  import bnva_pkg::*;
  logic clk;
  logic rstn;
  logic ce;
  logic wdt_idle_rst;
  logic [7:0] sfr_addr;
  logic sfr_ind;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic sfr_rvalid;
  logic nvm_busy;
  int err_count;
  int cmp_count;
  int cyc_count;
  logic [25:0] rows [14];
  logic [7:0] rv;

  bnva_top #(.WRITE_CYC(3)) i_dut (.clk(clk), .rstn(rstn), .ce(ce), .wdt_idle_rst(wdt_idle_rst),
    .sfr_addr(sfr_addr), .sfr_ind(sfr_ind), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .nvm_busy(nvm_busy));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 140 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc_count++;
    if (cyc_count == 3000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic ind, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_ind = ind;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic ind,
                       input logic [7:0] exp);
    int n;
    @(negedge clk);
    sfr_addr = a;
    sfr_ind = ind;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    n = 0;
    while (sfr_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    chk({nm, " valid"}, {7'h00, sfr_rvalid}, 8'h01);
    chk(nm, sfr_rdata, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (nvm_busy !== 1'b0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk("busy end", {7'h00, nvm_busy}, 8'h00);
  endtask

  // Unlock and trigger in consecutive cycles, never with a read trigger
  task automatic store(input logic [7:0] ad, input logic [7:0] dt);
    wr(NVM_ADDR_OFS, 1'b0, ad);
    wr(NVM_DATA_OFS, 1'b0, dt);
    @(negedge clk);
    sfr_addr = NVM_CTL_OFS;
    sfr_ind = 1'b1;
    sfr_wdata = 8'h08;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wdata = 8'h0C;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
    chk("store busy", {7'h00, nvm_busy}, 8'h01);
    wait_idle();
  endtask

  // Control reached through pointer one at 40H with bank 1 selected
  task automatic fetch(input logic [7:0] ad, input logic [7:0] exp);
    wr(NVM_ADDR_OFS, 1'b0, ad);
    wr(NVM_CTL_OFS, 1'b1, 8'h02);
    wr(NVM_CTL_OFS, 1'b1, 8'h03);
    wait_idle();
    rdchk("fetch ctl", NVM_CTL_OFS, 1'b1, 8'h02);
    rdchk("fetch data", NVM_DATA_OFS, 1'b0, exp);
  endtask

  task automatic do_reset(input logic wdt);
    @(negedge clk);
    rstn = 1'b0;
    wdt_idle_rst = wdt;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    wdt_idle_rst = 1'b0;
  endtask

  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    wdt_idle_rst = 1'b0;
    sfr_addr = 8'h00;
    sfr_ind = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    err_count = 0;
    cmp_count = 0;
    cyc_count = 0;
    // Rows: address, indirect, write, write data, expected read
    rows[0] = {NVM_ADDR_OFS, 1'b0, 1'b0, 8'h00, 8'h00};
    rows[1] = {NVM_DATA_OFS, 1'b0, 1'b0, 8'h00, 8'h00};
    rows[2] = {BANK_SEL_OFS, 1'b0, 1'b0, 8'h00, 8'h00};
    rows[3] = {NVM_ADDR_OFS, 1'b0, 1'b1, 8'hFF, 8'h1F};
    rows[4] = {NVM_DATA_OFS, 1'b0, 1'b1, 8'hA5, 8'hA5};
    rows[5] = {BANK_SEL_OFS, 1'b0, 1'b1, 8'hFF, 8'h01};
    rows[6] = {NVM_CTL_OFS, 1'b1, 1'b1, 8'hF0, 8'h80};
    rows[7] = {NVM_CTL_OFS, 1'b0, 1'b1, 8'hF0, 8'h00};
    rows[8] = {NVM_ADDR_OFS, 1'b0, 1'b1, 8'h0A, 8'h0A};
    rows[9] = {NVM_ADDR_OFS, 1'b1, 1'b1, 8'h1F, 8'h00};
    rows[10] = {NVM_ADDR_OFS, 1'b0, 1'b0, 8'h00, 8'h0A};
    rows[11] = {NVM_CTL_OFS, 1'b1, 1'b1, 8'h00, 8'h00};
    rows[12] = {BANK_SEL_OFS, 1'b0, 1'b1, 8'h00, 8'h00};
    rows[13] = {NVM_CTL_OFS, 1'b1, 1'b0, 8'h00, 8'h00};
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      if (rows[i][16] === 1'b1)
        wr(rows[i][25:18], rows[i][17], rows[i][15:8]);
      rdchk("row", rows[i][25:18], rows[i][17],
            rows[i][7:0]);
    end
    wr(BANK_SEL_OFS, 1'b0, 8'h01);
    store(8'h00, 8'h5A);
    store(8'h1F, 8'hC3);
    fetch(8'h00, 8'h5A);
    fetch(8'h1F, 8'hC3);
    // Trigger one idle cycle after unlock must be ignored
    wr(NVM_DATA_OFS, 1'b0, 8'h77);
    wr(NVM_CTL_OFS, 1'b1, 8'h08);
    wr(NVM_CTL_OFS, 1'b1, 8'h0C);
    chk("late trigger", {7'h00, nvm_busy}, 8'h00);
    fetch(8'h1F, 8'hC3);
    // Read trigger without unlock
    wr(NVM_CTL_OFS, 1'b1, 8'h00);
    wr(NVM_DATA_OFS, 1'b0, 8'h66);
    wr(NVM_CTL_OFS, 1'b1, 8'h01);
    chk("bare fetch", {7'h00, nvm_busy}, 8'h00);
    rdchk("bare fetch data", NVM_DATA_OFS, 1'b0, 8'h66);
    rdchk("bare fetch ctl", NVM_CTL_OFS, 1'b1, 8'h00);
    // Clock enable low freezes register writes
    @(negedge clk);
    ce = 1'b0;
    wr(NVM_ADDR_OFS, 1'b0, 8'h11);
    ce = 1'b1;
    rdchk("frozen addr", NVM_ADDR_OFS, 1'b0, 8'h1F);
    do_reset(1'b1);
    rdchk("wdt bank", BANK_SEL_OFS, 1'b0, 8'h01);
    rdchk("wdt ctl", NVM_CTL_OFS, 1'b1, 8'h00);
    rdchk("wdt addr", NVM_ADDR_OFS, 1'b0, 8'h00);
    do_reset(1'b0);
    rdchk("por bank", BANK_SEL_OFS, 1'b0, 8'h00);
    report_and_stop();
  end
endmodule
